/* File: hdl/frame_patch_loader.sv */
// frame length limit and static patch loader behind an apb slave
//
// Summary of operation
// - variable mode: register is max receive length
// - fixed mode: register is exact frame length
// - count payload bytes between sync and checksum
// - length offset never added to limit
// - at most nine modem ram locations patched
// - pointer is low byte, upper 0x1 implied
// - zero pointer means no patching
// - read pairs: target address, then data
// - zero target address byte ends patching
// - target byte is low byte, upper 0x3
// - modem ram lost in sleep, repatch on wake
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module frame_patch_loader (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // packet handler, same clock
    input wire logic frame_start,
    input wire logic payload_byte,
    output logic frame_fixed,
    output logic [7:0] frame_len_limit,
    output logic frame_end,
    output logic frame_oversize,
    // sleep state from the power controller, asynchronous
    input wire logic low_power_sleep_state,
    // modem configuration ram write port
    output logic mcr_wr_en,
    output logic [9:0] mcr_addr,
    output logic [7:0] mcr_data,
    output logic patch_busy
);

    // -------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------
    wire logic [9:0] reg_idx;
    wire logic access_phase;
    wire logic wr_commit;
    wire logic word_aligned;
    wire logic hit_max_len;
    wire logic hit_ptr;
    wire logic hit_ram;
    wire logic hit_ctrl;
    wire logic hit_stat;
    wire logic mapped;
    wire logic [4:0] bus_ram_idx;

    assign reg_idx = paddr[11:2];
    assign word_aligned = (paddr[1:0] == 2'h0);
    assign access_phase = psel & penable & ~pready;
    // a write lands only at the edge where pready is seen high
    assign wr_commit = psel & penable & pready & pwrite & ~pslverr;
    assign hit_max_len = word_aligned & (reg_idx == loader_pkg::IDX_MAX_FRAME_LENGTH);
    assign hit_ptr = word_aligned & (reg_idx == loader_pkg::IDX_PATCH_TABLE_POINTER);
    assign hit_ram = word_aligned & (reg_idx >= loader_pkg::IDX_RAM_LO)
                     & (reg_idx <= loader_pkg::IDX_RAM_HI);
    assign hit_ctrl = word_aligned & (reg_idx == loader_pkg::IDX_LOADER_CONTROL);
    assign hit_stat = word_aligned & (reg_idx == loader_pkg::IDX_LOADER_STATUS);
    assign mapped = hit_max_len | hit_ptr | hit_ram | hit_ctrl | hit_stat;
    assign bus_ram_idx = 5'(reg_idx - loader_pkg::IDX_RAM_LO);

    // -------------------------------------------------------------------
    // state declarations
    // -------------------------------------------------------------------
    logic [7:0] max_len_q;
    logic [7:0] ptr_q;
    logic fixed_q;
    logic [7:0] ram_q [loader_pkg::RAM_DEPTH];
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    loader_pkg::patch_state_type state_q;
    loader_pkg::patch_state_type state_d;
    logic [9:0] cur_q;
    logic [9:0] cur_d;
    logic [3:0] pairs_q;
    logic [3:0] pairs_d;
    logic busy_q;
    logic mcr_wr_q;
    logic [9:0] mcr_addr_q;
    logic [7:0] mcr_data_q;
    logic sleep_s1_q;
    logic sleep_s2_q;
    logic sleep_s3_q;
    logic [7:0] frame_cnt_q;
    logic frame_end_q;
    logic oversize_q;

    // -------------------------------------------------------------------
    // retained configuration ram, one flip-flop byte per entry
    // -------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < loader_pkg::RAM_DEPTH; gi++) begin : g_ram
            wire logic we;
            assign we = wr_commit & hit_ram & (bus_ram_idx == 5'(gi));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ram_q[gi] <= loader_pkg::RAM_ENTRY_RESET;
                end else if (we) begin
                    ram_q[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------------
    wire logic start_sw;
    assign start_sw = wr_commit & hit_ctrl & pwdata[loader_pkg::CTRL_START_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_len_q <= loader_pkg::MAX_FRAME_LENGTH_RESET;
            ptr_q <= loader_pkg::PATCH_POINTER_RESET;
            fixed_q <= loader_pkg::FIXED_MODE_RESET;
        end else begin
            if (wr_commit & hit_max_len) begin
                max_len_q <= pwdata[7:0];
            end
            if (wr_commit & hit_ptr) begin
                ptr_q <= pwdata[7:0];
            end
            if (wr_commit & hit_ctrl) begin
                fixed_q <= pwdata[loader_pkg::CTRL_FIXED_BIT];
            end
        end
    end

    // -------------------------------------------------------------------
    // read mux and apb answer
    // -------------------------------------------------------------------
    wire logic [31:0] status_word;
    wire logic [31:0] rd_word;
    wire logic [4:0] rd_ram_idx;

    assign rd_ram_idx = hit_ram ? bus_ram_idx : 5'h00;
    assign status_word = (32'(frame_cnt_q) << loader_pkg::STAT_FRAME_CNT_LSB)
                       | (32'(pairs_q) << loader_pkg::STAT_COUNT_LSB)
                       | (32'(oversize_q) << loader_pkg::STAT_OVERSIZE_BIT)
                       | (32'(state_q != loader_pkg::ST_IDLE) << loader_pkg::STAT_BUSY_BIT);
    assign rd_word = hit_max_len ? {24'h000000, max_len_q}
                   : hit_ptr ? {24'h000000, ptr_q}
                   : hit_ram ? {24'h000000, ram_q[rd_ram_idx]}
                   : hit_ctrl ? (32'(fixed_q) << loader_pkg::CTRL_FIXED_BIT)
                   : hit_stat ? status_word
                   : 32'h00000000;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= access_phase;
            pslverr_q <= access_phase & ~mapped;
            if (access_phase) begin
                prdata_q <= (pwrite | ~mapped) ? 32'h00000000 : rd_word;
            end
        end
    end

    // -------------------------------------------------------------------
    // sleep synchroniser and wake detect
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
            sleep_s3_q <= 1'b0;
        end else begin
            sleep_s1_q <= low_power_sleep_state;
            sleep_s2_q <= sleep_s1_q;
            sleep_s3_q <= sleep_s2_q;
        end
    end

    wire logic wake;
    // modem ram came back empty, so the patches must be replayed
    assign wake = sleep_s3_q & ~sleep_s2_q;

    // -------------------------------------------------------------------
    // patch sequencer
    // -------------------------------------------------------------------
    wire logic start_req;
    wire logic [9:0] start_addr;
    wire logic start_ok;
    wire logic cur_in_range;
    wire logic [4:0] cur_idx;
    wire logic [4:0] data_idx;
    wire logic [7:0] tgt_byte;
    wire logic [7:0] data_byte;

    assign start_req = start_sw | wake;
    assign start_addr = {loader_pkg::RAM_UPPER_BITS, ptr_q};
    // a pointer outside the region is refused rather than followed
    assign start_ok = (ptr_q != loader_pkg::PATCH_DISABLED)
                      & (start_addr >= loader_pkg::IDX_RAM_LO)
                      & (start_addr <= loader_pkg::IDX_RAM_HI);
    // a pair needs two bytes, so the address byte must sit below the top
    assign cur_in_range = (cur_q >= loader_pkg::IDX_RAM_LO)
                          & (cur_q < loader_pkg::IDX_RAM_HI);
    assign cur_idx = cur_in_range ? 5'(cur_q - loader_pkg::IDX_RAM_LO) : 5'h00;
    assign data_idx = cur_in_range ? 5'(cur_idx + 5'h01) : 5'h00;
    assign tgt_byte = ram_q[cur_idx];
    assign data_byte = ram_q[data_idx];

    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        pairs_d = pairs_q;
        case (state_q)
            loader_pkg::ST_IDLE: begin
                if (start_req & start_ok) begin
                    state_d = loader_pkg::ST_FETCH;
                    cur_d = start_addr;
                    pairs_d = 4'h0;
                end
            end
            loader_pkg::ST_FETCH: begin
                if (!cur_in_range || pairs_q == loader_pkg::PATCH_MAX_PAIRS) begin
                    state_d = loader_pkg::ST_IDLE;
                end else if (tgt_byte == loader_pkg::PATCH_TERMINATOR) begin
                    state_d = loader_pkg::ST_IDLE;
                end else begin
                    state_d = loader_pkg::ST_WRITE;
                end
            end
            loader_pkg::ST_WRITE: begin
                state_d = loader_pkg::ST_FETCH;
                cur_d = 10'(cur_q + 10'h002);
                pairs_d = 4'(pairs_q + 4'h1);
            end
            default: begin
                state_d = loader_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= loader_pkg::ST_IDLE;
            cur_q <= 10'h000;
            pairs_q <= 4'h0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            pairs_q <= pairs_d;
            // taken from the next state so it tracks state_q cycle for cycle
            busy_q <= (state_d != loader_pkg::ST_IDLE);
        end
    end

    // write strobe issued in the write state, registered onto the port
    wire logic issue_wr;
    assign issue_wr = (state_q == loader_pkg::ST_WRITE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcr_wr_q <= 1'b0;
            mcr_addr_q <= 10'h000;
            mcr_data_q <= 8'h00;
        end else begin
            mcr_wr_q <= issue_wr;
            if (issue_wr) begin
                mcr_addr_q <= {loader_pkg::MCR_UPPER_BITS, tgt_byte};
                mcr_data_q <= data_byte;
            end
        end
    end

    // -------------------------------------------------------------------
    // payload length counter and limit check
    // -------------------------------------------------------------------
    wire logic [8:0] cnt_next;
    assign cnt_next = {1'b0, frame_cnt_q} + 9'h001;

    // the counter sees only payload strobes, so sync and checksum never count,
    // and the limit is compared raw with no length offset folded in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt_q <= 8'h00;
            frame_end_q <= 1'b0;
            oversize_q <= 1'b0;
        end else begin
            frame_end_q <= 1'b0;
            if (frame_start) begin
                frame_cnt_q <= 8'h00;
                oversize_q <= 1'b0;
            end else if (payload_byte) begin
                if (cnt_next[8] == 1'b0) begin
                    frame_cnt_q <= cnt_next[7:0];
                end
                if (fixed_q && cnt_next == {1'b0, max_len_q}) begin
                    frame_end_q <= 1'b1;
                end
                if (!fixed_q && cnt_next > {1'b0, max_len_q}) begin
                    oversize_q <= 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign frame_fixed = fixed_q;
    assign frame_len_limit = max_len_q;
    assign frame_end = frame_end_q;
    assign frame_oversize = oversize_q;
    assign mcr_wr_en = mcr_wr_q;
    assign mcr_addr = mcr_addr_q;
    assign mcr_data = mcr_data_q;
    // busy comes off its own flop, so the port carries no decode glitch
    // while the one-hot state changes
    assign patch_busy = busy_q;

endmodule

`default_nettype wire

/* File: common/loader_pkg.sv */
// constants and types for the frame length limit and static patch loader
package loader_pkg;

    // -------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [9:0] IDX_MAX_FRAME_LENGTH = 10'h127;
    localparam logic [9:0] IDX_PATCH_TABLE_POINTER = 10'h128;
    localparam logic [9:0] IDX_RAM_LO = 10'h12a;
    localparam logic [9:0] IDX_RAM_HI = 10'h13d;
    localparam logic [9:0] IDX_LOADER_CONTROL = 10'h140;
    localparam logic [9:0] IDX_LOADER_STATUS = 10'h141;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int CTRL_FIXED_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OVERSIZE_BIT = 1;
    localparam int STAT_COUNT_LSB = 4;
    localparam int STAT_FRAME_CNT_LSB = 8;

    // -------------------------------------------------------------------
    // reset values and sizes
    // -------------------------------------------------------------------
    localparam logic [7:0] MAX_FRAME_LENGTH_RESET = 8'h00;
    localparam logic [7:0] PATCH_POINTER_RESET = 8'h00;
    localparam logic [7:0] RAM_ENTRY_RESET = 8'h00;
    localparam logic FIXED_MODE_RESET = 1'b0;
    localparam int RAM_DEPTH = 20;
    localparam logic [3:0] PATCH_MAX_PAIRS = 4'h9;
    localparam logic [1:0] RAM_UPPER_BITS = 2'h1;
    localparam logic [1:0] MCR_UPPER_BITS = 2'h3;
    localparam logic [7:0] PATCH_DISABLED = 8'h00;
    localparam logic [7:0] PATCH_TERMINATOR = 8'h00;

    // -------------------------------------------------------------------
    // patch sequencer states
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_WRITE = 3'b100
    } patch_state_type;

endpackage

/* File: bench/frame_patch_loader_assertions.sv */
// concurrent checks on the frame limit and patch loader ports
`timescale 1ns/1ps
`default_nettype none
module frame_patch_loader_assertions (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // packet handler
    input wire logic frame_start,
    input wire logic payload_byte,
    input wire logic frame_fixed,
    input wire logic [7:0] frame_len_limit,
    input wire logic frame_end,
    input wire logic frame_oversize,
    // modem ram port
    input wire logic mcr_wr_en,
    input wire logic [9:0] mcr_addr,
    input wire logic patch_busy
);
    // ------------------------------------------------------------
    // payload count mirror, saturating so long frames never wrap
    // ------------------------------------------------------------
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [8:0] nxt;
    assign nxt = {1'b0, cnt_q} + 9'h001;
    assign cnt_d = frame_start ? 8'h00 : (payload_byte && !nxt[8]) ? nxt[7:0] : cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_byte;
        payload_byte && !frame_start;
    endsequence
    a_one_wait: assert property (s_wait |=> pready) else $error("no ready after one wait");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_fixed_end: assert property (s_byte ##0 (frame_fixed && frame_len_limit != 8'h00
        && !nxt[8] && nxt[7:0] == frame_len_limit) |=> frame_end)
        else $error("fixed frame end missing");
    a_over_set: assert property (s_byte ##0 (!frame_fixed && nxt > {1'b0, frame_len_limit})
        |=> frame_oversize) else $error("oversize not flagged");
    a_over_clear: assert property (frame_start |=> !frame_oversize)
        else $error("oversize not cleared");
    a_mcr_upper: assert property (mcr_wr_en |-> mcr_addr[9:8] == 2'b11)
        else $error("modem ram upper bits wrong");
    a_wr_spacing: assert property (mcr_wr_en |=> !mcr_wr_en)
        else $error("writes not spaced");
    a_wr_busy: assert property (mcr_wr_en |-> $past(patch_busy))
        else $error("write outside a run");
endmodule

bind frame_patch_loader frame_patch_loader_assertions i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .payload_byte(payload_byte), .frame_fixed(frame_fixed),
    .frame_len_limit(frame_len_limit), .frame_end(frame_end),
    .frame_oversize(frame_oversize), .mcr_wr_en(mcr_wr_en), .mcr_addr(mcr_addr),
    .patch_busy(patch_busy));
`default_nettype wire

/* File: bench/test_frame_patch_loader.sv */
// self-checking bench for the frame limit and static patch loader
`timescale 1ns/1ps
`default_nettype none
module test_frame_patch_loader;
    localparam logic [9:0] MAXL = loader_pkg::IDX_MAX_FRAME_LENGTH;
    localparam logic [9:0] PTR = loader_pkg::IDX_PATCH_TABLE_POINTER;
    localparam logic [9:0] CTL = loader_pkg::IDX_LOADER_CONTROL;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic frame_start = 1'b0, payload_byte = 1'b0, sleep = 1'b0;
    logic pready, pslverr, frame_fixed, frame_end, frame_oversize, mcr_wr_en, patch_busy, e;
    logic [31:0] prdata, r;
    logic [7:0] frame_len_limit, mcr_data;
    logic [9:0] mcr_addr;
    logic [17:0] wq[$];
    int fails = 0, comparisons = 0, ends = 0;

    frame_patch_loader i_frame_patch_loader (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_start(frame_start),
        .payload_byte(payload_byte), .frame_fixed(frame_fixed),
        .frame_len_limit(frame_len_limit), .frame_end(frame_end),
        .frame_oversize(frame_oversize), .low_power_sleep_state(sleep),
        .mcr_wr_en(mcr_wr_en), .mcr_addr(mcr_addr), .mcr_data(mcr_data),
        .patch_busy(patch_busy));

    initial forever #25 pclk = ~pclk;

    always @(posedge pclk) begin
        if (mcr_wr_en === 1'b1) wq.push_back({mcr_addr, mcr_data});
        if (frame_end === 1'b1) ends++;
    end

    // ------------------------------------------------------------
    // apb master and helpers
    // ------------------------------------------------------------
    task automatic close_out;
        if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fails++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        xfer(1'b1, {i, 2'b00}, {24'h0, d});
    endtask
    task automatic rd(input logic [9:0] i, input logic [31:0] exp);
        xfer(1'b0, {i, 2'b00}, 32'h0);
        check($sformatf("register %h", i), r, exp);
    endtask
    // a wake run waits out the sleep synchroniser before looking for idle
    task automatic run_patch(input logic wake);
        int n;
        wq.delete();
        if (wake) begin
            @(posedge pclk);
            sleep <= 1'b1;
            repeat (4) @(posedge pclk);
            sleep <= 1'b0;
        end else begin
            wr(CTL, 8'h02);
        end
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((n < 6 || patch_busy !== 1'b0) && n < 200);
        if (patch_busy !== 1'b0) begin
            fails++;
            close_out();
        end
        repeat (2) @(posedge pclk);
    endtask
    task automatic frame(input int nb);
        @(posedge pclk);
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        repeat (nb) begin
            payload_byte <= 1'b1;
            @(posedge pclk);
        end
        payload_byte <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(MAXL, 32'h0);
        rd(PTR, 32'h0);
        xfer(1'b0, 12'h600, 32'h0);
        check("unmapped error", {31'h0, e}, 32'h1);
        xfer(1'b1, 12'h49d, 32'h55);
        check("misaligned error", {31'h0, e}, 32'h1);
        rd(MAXL, 32'h0);
        run_patch(1'b0);
        check("writes", 32'(wq.size()), 32'h0);
        wr(PTR, 8'h2b);
        wr(10'h12b, 8'h5e);
        wr(10'h12c, 8'h46);
        wr(10'h12d, 8'h5f);
        wr(10'h12e, 8'h78);
        wr(10'h12f, 8'h00);
        run_patch(1'b0);
        check("writes", 32'(wq.size()), 32'h2);
        check("pair", {14'h0, wq[0]}, {14'h0, 10'h35e, 8'h46});
        check("pair", {14'h0, wq[1]}, {14'h0, 10'h35f, 8'h78});
        rd(loader_pkg::IDX_LOADER_STATUS, 32'h20);
        for (int k = 0; k < 20; k++) begin
            wr(loader_pkg::IDX_RAM_LO + 10'(k), 8'(k) + (k[0] ? 8'ha0 : 8'h10));
        end
        wr(PTR, 8'h2a);
        run_patch(1'b0);
        check("writes", 32'(wq.size()), 32'h9);
        for (int j = 0; j < 9; j++) begin
            r = {14'h0, 2'b11, 8'(2 * j) + 8'h10, 8'(2 * j + 1) + 8'ha0};
            check("pair", {14'h0, wq[j]}, r);
        end
        run_patch(1'b1);
        check("wake writes", 32'(wq.size()), 32'h9);
        wr(CTL, 8'h01);
        wr(MAXL, 8'h04);
        // the limit register updates at the commit edge, so look one edge later
        @(posedge pclk);
        check("fixed", {31'h0, frame_fixed}, 32'h1);
        check("limit", {24'h0, frame_len_limit}, 32'h4);
        ends = 0;
        frame(3);
        frame(4);
        check("frame ends", 32'(ends), 32'h1);
        wr(CTL, 8'h00);
        wr(MAXL, 8'h03);
        frame(3);
        check("oversize", {31'h0, frame_oversize}, 32'h0);
        frame(4);
        check("oversize", {31'h0, frame_oversize}, 32'h1);
        rd(loader_pkg::IDX_LOADER_STATUS, 32'h0492);
        // a pair that starts one below the top still fits, then the run stops
        wr(PTR, 8'h3c);
        run_patch(1'b0);
        check("top writes", 32'(wq.size()), 32'h1);
        check("top pair", {14'h0, wq[0]}, {14'h0, 10'h322, 8'hb3});
        // an address byte on the last location has no data byte inside
        wr(PTR, 8'h3d);
        run_patch(1'b0);
        check("edge writes", 32'(wq.size()), 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
